// [pkg/hvim_pkg.sv]
/*
 * Constants for the interlock loop and insulation monitor block.
 * Assumes a 250 MHz system clock and a slow external loop and monitor.
 */
package hvim_pkg;
    // System clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Driven loop frequency in hertz and duty cycle in percent.
    localparam int unsigned LOOP_FREQ_HZ = 100;
    localparam int unsigned LOOP_DUTY_PCT = 50;
    // Cycles in one half period of the driven square wave.
    localparam int unsigned HALF_PERIOD_CYC = 32'(
        (64'd1000000000000 * LOOP_DUTY_PCT / 100)
        / (64'd1 * LOOP_FREQ_HZ * CLK_PERIOD_PS));
    // Gate period for the return measurement in milliseconds.
    localparam int unsigned GATE_MS = 100;
    localparam int unsigned GATE_CYC =
        32'((64'd1000000000 * GATE_MS) / CLK_PERIOD_PS);
    // Rising edges expected in one gate period.
    localparam logic [15:0] EXPECT_EDGES =
        16'((LOOP_FREQ_HZ * GATE_MS) / 1000);
    // Cycles in one second, the unit of the settle time.
    localparam int unsigned SECOND_CYC =
        32'(64'd1000000000000 / CLK_PERIOD_PS);
    // Suggested settle time in seconds.
    localparam logic [7:0] SETTLE_S_DEFAULT = 8'h14;
    // Number of selectable frequency-capable return pins.
    localparam int unsigned NUM_FREQ_PINS = 4;
    // Contactor gate source encodings.
    typedef enum logic [1:0] {
        GATE_IGNORE = 2'h0,
        GATE_RAW = 2'h1,
        GATE_FILTERED = 2'h2
    } hvim_gate_src_t;
endpackage

// [hdl/hvim_sync.sv]
/*
 * Two-flop synchroniser for one asynchronous pin.
 * Assumes the pin is slow against the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module hvim_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Pin and result
    input wire logic pinIn,
    output logic pinSync
);
    logic stage1;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            pinSync <= 1'b0;
        end else if (clkEn) begin
            stage1 <= pinIn;
            pinSync <= stage1;
        end
    end
endmodule
`default_nettype wire

// [hdl/hvim_monitor.sv]
/*
 * Interlock loop driver and checker with insulation monitor filtering.
 * Assumes resetn is asserted on each wake and a nonvolatile store
 * outside mirrors the latched fault flag across power cycles.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Drive loop with 100 Hz square wave.
// RULE2: Measure return frequency, compare to driven.
// RULE3: Configurable tolerance on frequency match.
// RULE4: Loop state is 1 when frequencies agree.
// RULE5: Check disabled means loop never gates.
// RULE6: Bypass forces loop treated as intact.
// RULE7: Withhold contactor enable without loop.
// RULE8: Configuration selects the return input pin.
// RULE9: Monitor status high healthy, low fault.
// RULE10: Ignore insulation status until settle time.
// RULE11: After settle, fault flag one on fault.
// RULE12: Selector picks raw, filtered or ignore gating.
// RULE13: Latched fault flag cleared by toggling clear.
// RULE14: Expose raw insulation level separately.
// RULE15: Start on wake, settle timer from wake.
// RULE16: Count rising edges over fixed gate period.
module hvim_monitor (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Wake and configuration
    input wire logic wakeIn,
    input wire logic interlock_check_enable,
    input wire logic interlock_bypass,
    input wire logic [1:0] interlock_input_select,
    input wire logic [7:0] interlock_freq_window,
    input wire logic [7:0] insulation_settle_time,
    input wire logic [1:0] insulation_contactor_gate_source,
    input wire logic insulation_latch_clear,
    // Pins
    input wire logic [3:0] freqPinIn,
    input wire logic insulationStatusIn,
    output logic interlockDriveOut,
    // Status
    output logic [15:0] interlock_freq_measured,
    output logic [15:0] interlock_freq_driven,
    output logic interlock_loop_state,
    output logic insulation_input_raw,
    output logic insulation_input_filtered,
    output logic insulation_fault_flag,
    output logic insulation_fault_latched,
    output logic settleDone,
    output logic contactorEnable
);
    logic [3:0] pinSync;
    logic wakeSync;
    logic insSync;
    logic selPrev;
    logic [31:0] halfCnt;
    logic [31:0] gateCnt;
    logic [15:0] edgeCnt;
    logic [15:0] measDiff;
    logic freqMatch;
    logic running;
    logic [31:0] secCnt;
    logic [7:0] secElapsed;
    logic clearPrev;
    logic insFault;
    logic interlockOk;
    logic insBlock;
    logic next_contactorEnable;

    // One synchroniser per return pin and for the monitor and wake lines.
    genvar gi;
    generate
        for (gi = 0; gi < hvim_pkg::NUM_FREQ_PINS; gi++) begin : g_sync
            hvim_sync u_sync (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .clkEn(clkEn),
                .pinIn(freqPinIn[gi]),
                .pinSync(pinSync[gi])
            );
        end
    endgenerate

    hvim_sync u_wake (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .pinIn(wakeIn),
        .pinSync(wakeSync)
    );

    hvim_sync u_ins (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .pinIn(insulationStatusIn),
        .pinSync(insSync)
    );

    // RULE15: run on wake
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            running <= 1'b0;
        end else if (clkEn) begin
            running <= wakeSync;
        end
    end

    // RULE1: square wave drive
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            halfCnt <= 32'h0;
            interlockDriveOut <= 1'b0;
        end else if (clkEn) begin
            if (!running) begin
                halfCnt <= 32'h0;
                interlockDriveOut <= 1'b0;
            end else if (halfCnt == hvim_pkg::HALF_PERIOD_CYC - 1) begin
                halfCnt <= 32'h0;
                interlockDriveOut <= ~interlockDriveOut;
            end else begin
                halfCnt <= halfCnt + 32'h1;
            end
        end
    end

    // RULE16: gated edge count
    // RULE8: selected return pin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gateCnt <= 32'h0;
            edgeCnt <= 16'h0;
            selPrev <= 1'b0;
            interlock_freq_measured <= 16'h0;
        end else if (clkEn) begin
            selPrev <= pinSync[interlock_input_select];
            if (gateCnt == hvim_pkg::GATE_CYC - 1) begin
                gateCnt <= 32'h0;
                edgeCnt <= 16'h0;
                interlock_freq_measured <= edgeCnt;
            end else begin
                gateCnt <= gateCnt + 32'h1;
                if (pinSync[interlock_input_select] && !selPrev) begin
                    edgeCnt <= edgeCnt + 16'h1;
                end
            end
        end
    end

    // RULE2: compare with driven
    // RULE3: tolerance window
    assign measDiff = (interlock_freq_measured > hvim_pkg::EXPECT_EDGES)
        ? interlock_freq_measured - hvim_pkg::EXPECT_EDGES
        : hvim_pkg::EXPECT_EDGES - interlock_freq_measured;
    assign freqMatch = measDiff <= {8'h0, interlock_freq_window};

    // RULE4: loop state output
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            interlock_loop_state <= 1'b0;
            interlock_freq_driven <= 16'h0;
        end else if (clkEn) begin
            interlock_loop_state <= running && freqMatch;
            interlock_freq_driven <= running ? hvim_pkg::EXPECT_EDGES : 16'h0;
        end
    end

    // RULE15: settle timer from wake
    // RULE10: settle time in seconds
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            secCnt <= 32'h0;
            secElapsed <= 8'h0;
            settleDone <= 1'b0;
        end else if (clkEn) begin
            if (!running) begin
                secCnt <= 32'h0;
                secElapsed <= 8'h0;
                settleDone <= 1'b0;
            end else if (secElapsed >= insulation_settle_time) begin
                settleDone <= 1'b1;
            end else if (secCnt == hvim_pkg::SECOND_CYC - 1) begin
                secCnt <= 32'h0;
                secElapsed <= secElapsed + 8'h1;
            end else begin
                secCnt <= secCnt + 32'h1;
            end
        end
    end

    // RULE9: low means fault
    assign insFault = !insSync;

    // RULE14: raw level exposed
    // RULE11: filtered fault flag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            insulation_input_raw <= 1'b0;
            insulation_input_filtered <= 1'b1;
            insulation_fault_flag <= 1'b0;
        end else if (clkEn) begin
            insulation_input_raw <= insSync;
            if (settleDone) begin
                insulation_input_filtered <= insSync;
                insulation_fault_flag <= insFault;
            end
        end
    end

    // RULE13: latch, clear on toggle
    // A fault in the clearing cycle wins so it is never lost.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clearPrev <= 1'b0;
            insulation_fault_latched <= 1'b0;
        end else if (clkEn) begin
            clearPrev <= insulation_latch_clear;
            if (settleDone && insFault) begin
                insulation_fault_latched <= 1'b1;
            end else if (insulation_latch_clear != clearPrev) begin
                insulation_fault_latched <= 1'b0;
            end
        end
    end

    // RULE5: disabled never gates
    // RULE6: bypass forces intact
    assign interlockOk = !interlock_check_enable || interlock_bypass
        || interlock_loop_state;

    // RULE12: gate source select
    always_comb begin
        unique case (insulation_contactor_gate_source)
            hvim_pkg::GATE_RAW: insBlock = !insulation_input_raw;
            hvim_pkg::GATE_FILTERED: insBlock = insulation_fault_flag
                || !settleDone;
            default: insBlock = 1'b0;
        endcase
    end

    // RULE7: withhold contactor enable
    assign next_contactorEnable = running && interlockOk && !insBlock;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            contactorEnable <= 1'b0;
        end else if (clkEn) begin
            contactorEnable <= next_contactorEnable;
        end
    end

    // All checks run on the one system clock and sleep in reset.
    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    property p_enable_needs_loop;
        (clkEn && interlock_check_enable && !interlock_bypass
            && !interlock_loop_state) |=> !contactorEnable;
    endproperty
    a_enable_needs_loop: assert property (p_enable_needs_loop) // RULE7
        else $error("Contactor enabled without interlock loop.");
    property p_half_period;
        (clkEn && running && halfCnt == hvim_pkg::HALF_PERIOD_CYC - 1)
            |=> $changed(interlockDriveOut) || !$past(clkEn);
    endproperty
    a_half_period: assert property (p_half_period) // RULE1
        else $error("Drive did not toggle at half period.");
    property p_loop_state;
        (clkEn && running && !freqMatch) |=> !interlock_loop_state;
    endproperty
    a_loop_state: assert property (p_loop_state) // RULE4
        else $error("Loop state high with frequency mismatch.");
    property p_filter_hold;
        (clkEn && !settleDone) |=> $stable(insulation_fault_flag);
    endproperty
    a_filter_hold: assert property (p_filter_hold) // RULE10
        else $error("Fault flag changed before settle time.");
    property p_fault_flag;
        (clkEn && settleDone && !insSync) |=> insulation_fault_flag;
    endproperty
    a_fault_flag: assert property (p_fault_flag) // RULE11
        else $error("Fault flag not set on fault after settle.");
    property p_latch;
        (clkEn && settleDone && !insSync) |=> insulation_fault_latched;
    endproperty
    a_latch: assert property (p_latch) // RULE13
        else $error("Fault not latched.");
    property p_raw;
        clkEn |=> insulation_input_raw == $past(insSync);
    endproperty
    a_raw: assert property (p_raw) // RULE14
        else $error("Raw status does not follow input.");
    property p_bypass;
        (clkEn && interlock_bypass && running && !insBlock)
            |=> contactorEnable;
    endproperty
    a_bypass: assert property (p_bypass) // RULE6
        else $error("Bypass did not allow contactor enable.");
endmodule
`default_nettype wire

// [test/hvim_partner.sv]
/*
 * Far-side model: loop wiring and the insulation monitor.
 * Assumes the bench picks the return pin and the fault level.
 */
`timescale 1ns/1ps
`default_nettype none
module hvim_partner (
    // Clock
    input wire logic sys_clk,
    // Loop wiring
    input wire logic driveIn,
    input wire logic [1:0] pinSel,
    output logic [3:0] freqPin,
    // Monitor
    input wire logic insFault,
    output logic statusOut
);
    logic noise = 1'b0;
    always @(posedge sys_clk) begin
        noise <= ~noise;
    end
    // Unwired pins carry a changing pattern so a stale level never helps.
    always_comb begin
        freqPin = {4{noise}};
        freqPin[pinSel] = driveIn;
    end
    assign statusOut = ~insFault;
endmodule
`default_nettype wire

// [test/hv_interlock_insulation_monitor_tb.sv]
/*
 * Self-checking bench for the interlock and insulation monitor.
 * Assumes gate counts are out of reach, so loop gating is checked
 * before the first gate ends.
 */
`timescale 1ns/1ps
`default_nettype none
module hv_interlock_insulation_monitor_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic wakeIn = 1'b0;
    logic chkEn = 1'b0;
    logic bypass = 1'b0;
    logic [1:0] pinSel = 2'h0;
    logic [7:0] window = 8'h02;
    logic [7:0] settle = 8'h05;
    logic [1:0] gateSrc = 2'h0;
    logic clr = 1'b0;
    logic clkEn = 1'b1;
    logic insFault = 1'b0;
    logic [3:0] freqPin;
    logic status, drive, loopSt, insRaw, insFilt, fault, latched;
    logic settleDone, contactor;
    logic [15:0] measured, driven;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    hvim_monitor u_hvim_monitor (
        .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .wakeIn(wakeIn), .interlock_check_enable(chkEn),
        .interlock_bypass(bypass), .interlock_input_select(pinSel),
        .interlock_freq_window(window), .insulation_settle_time(settle),
        .insulation_contactor_gate_source(gateSrc),
        .insulation_latch_clear(clr), .freqPinIn(freqPin),
        .insulationStatusIn(status), .interlockDriveOut(drive),
        .interlock_freq_measured(measured),
        .interlock_freq_driven(driven), .interlock_loop_state(loopSt),
        .insulation_input_raw(insRaw), .insulation_input_filtered(insFilt),
        .insulation_fault_flag(fault), .insulation_fault_latched(latched),
        .settleDone(settleDone), .contactorEnable(contactor)
    );

    hvim_partner u_hvim_partner (
        .sys_clk(sys_clk), .driveIn(drive), .pinSel(pinSel),
        .freqPin(freqPin), .insFault(insFault), .statusOut(status)
    );

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        $display("Counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang counts as a mismatch.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wake_up();
        @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        wakeIn <= 1'b1;
        wt(8);
    endtask

    // Model: loop gating is passed only when unchecked or bypassed, since
    // no gate period can end within this run.
    function automatic logic exp_contactor(input int s);
        logic insOk;
        insOk = 1'b1;
        if (s == 1 || s == 2) begin
            insOk = ~insFault;
        end
        return wakeIn & (~chkEn | bypass) & insOk;
    endfunction

    initial begin
        void'($urandom(32'hbd49));
        pinSel <= 2'($urandom % 4);
        window <= 8'($urandom % 8);
        wt(15);
        chk(contactor, 0);
        chk(insFilt, 1);
        chk(latched, 0);
        $display("test reset done");
        wake_up();
        @(posedge sys_clk);
        insFault <= 1'b1;
        gateSrc <= 2'h2;
        wt(8);
        chk(insRaw, 0);
        chk(insFilt, 1);
        chk(fault, 0);
        chk(settleDone, 0);
        chk(driven, hvim_pkg::EXPECT_EDGES);
        chk(drive, 0);
        chk(measured, 16'h0);
        chk(loopSt, 0);
        chk(contactor, 0);
        $display("test settle hold done");
        @(posedge sys_clk);
        resetn <= 1'b0;
        wakeIn <= 1'b0;
        settle <= 8'h00;
        insFault <= 1'b0;
        repeat (16) @(posedge sys_clk);
        wake_up();
        chk(settleDone, 1);
        chk(fault, 0);
        @(posedge sys_clk);
        insFault <= 1'b1;
        wt(8);
        chk(fault, 1);
        chk(insFilt, 0);
        @(posedge sys_clk);
        insFault <= 1'b0;
        wt(8);
        chk(latched, 1);
        @(posedge sys_clk);
        clr <= ~clr;
        wt(8);
        chk(latched, 0);
        $display("test latch done");
        // A frozen enable must hold every state, the sync flops too.
        @(posedge sys_clk);
        clkEn <= 1'b0;
        insFault <= 1'b1;
        wt(8);
        chk(insRaw, 1);
        chk(latched, 0);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        wt(8);
        chk(insRaw, 0);
        chk(latched, 1);
        // A clear while the fault still stands loses to the set.
        @(posedge sys_clk);
        clr <= ~clr;
        wt(8);
        chk(latched, 1);
        @(posedge sys_clk);
        insFault <= 1'b0;
        wt(8);
        @(posedge sys_clk);
        clr <= ~clr;
        wt(8);
        chk(latched, 0);
        $display("test enable done");
        // Sweep every gate source in each loop mode.
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 4; s++) begin
                for (int f = 0; f < 2; f++) begin
                    @(posedge sys_clk);
                    chkEn <= (m != 0);
                    bypass <= (m == 2);
                    gateSrc <= 2'(s);
                    insFault <= f[0];
                    wt(8);
                    chk(contactor, exp_contactor(s));
                    chk(latched, 16'(f));
                    @(posedge sys_clk);
                    insFault <= 1'b0;
                    wt(8);
                    @(posedge sys_clk);
                    clr <= ~clr;
                    wt(8);
                end
            end
        end
        $display("test gating done");
        @(posedge sys_clk);
        wakeIn <= 1'b0;
        wt(8);
        chk(contactor, 0);
        $display("test sleep done");
        final_report();
    end
endmodule
`default_nettype wire
